// ===== cbm_pkg.sv
// Summary of operation
// - Mask C source from select bits 11-8.
// - Mask B source from select bits 7-4.
// - Mask A source from select bits 3-0.
// - Unused bits ignore writes, read zero.
// - Polarity 0 blocks a high comparator level.
// - Control bit 13 feeds true C to OR.
// - Control bit 12 feeds inverted C to OR.
// - Control bit 11 feeds true B to OR.
// - Control bit 10 feeds inverted B to OR.
// - Control bit 9 feeds true A to OR.
// - Control bit 8 feeds inverted A to OR.
// - Control bit 7 feeds inverted AND to OR.
// - Control bit 6 feeds true AND to OR.
// - Control bit 5 feeds true C to AND.
// - Control bit 4 feeds inverted C to AND.
// - Control bit 3 feeds true B to AND.
// - Control bit 2 feeds inverted B to AND.
// - Control bit 1 feeds true A to AND.
// - Control bit 0 feeds inverted A to AND.
package cbm_pkg;
  localparam logic [11:0] ADDR_SRC     = 12'h000;
  localparam logic [11:0] ADDR_CON     = 12'h004;
  localparam logic [15:0] SRC_WMASK    = 16'h0fff;
  localparam logic [15:0] CON_WMASK    = 16'hbfff;
  localparam logic [15:0] RST_VAL      = 16'h0000;
  localparam int          SRC_C_LSB    = 8;
  localparam int          SRC_B_LSB    = 4;
  localparam int          SRC_A_LSB    = 0;
  localparam int          POL_BIT      = 15;
  localparam int          OR_C_T       = 13;
  localparam int          OR_C_N       = 12;
  localparam int          OR_B_T       = 11;
  localparam int          OR_B_N       = 10;
  localparam int          OR_A_T       = 9;
  localparam int          OR_A_N       = 8;
  localparam int          AND_INV_OR   = 7;
  localparam int          AND_TRUE_OR  = 6;
  localparam int          AND_C_T      = 5;
  localparam int          AND_C_N      = 4;
  localparam int          AND_B_T      = 3;
  localparam int          AND_B_N      = 2;
  localparam int          AND_A_T      = 1;
  localparam int          AND_A_N      = 0;
  localparam int          NUM_SRC      = 16;
  localparam int          SEL_W        = 4;
  localparam logic [3:0]  SEL_TRIG18   = 4'hc;
  localparam logic [3:0]  SEL_TRIG19   = 4'hd;
  localparam logic [3:0]  SEL_FAULT_IN_2     = 4'he;
  localparam logic [3:0]  SEL_FAULT_IN_4     = 4'hf;
  localparam logic [15:0] AND_FIELD    = 16'h003f;
  localparam logic [15:0] OR_FIELD     = 16'h3fc0;
endpackage

// ===== cbm_src_model.sv
`timescale 1ns/1ps
module cbm_src_model (
  input  wire logic        mclk,               // System clock.
  output logic      [11:0] pwm_outs = 12'h000, // Generator outputs.
  output logic             trig_18  = 1'b0,    // Trigger output 18.
  output logic             trig_19  = 1'b0,    // Trigger output 19.
  output logic             fault_2  = 1'b0,    // Fault input 2.
  output logic             fault_4  = 1'b0,    // Fault input 4.
  output logic             cmp_in   = 1'b0     // Comparator level.
);
  integer seed = 32'hbfff4195;
  // Fresh levels every cycle, so each select code sees both values of its source.
  always @(posedge mclk) begin
    {cmp_in, fault_4, fault_2, trig_19, trig_18, pwm_outs} <= 17'($random(seed));
  end
endmodule

// ===== cbm_top.sv
`timescale 1ns/1ps
module cbm_top (
  input  wire logic        mclk,          // System clock.
  input  wire logic        rst_n,         // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB write.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire logic [11:0] pwm_outs,      // Generator outputs, low side on even bits.
  input  wire logic        trig_gen_out_18, // Trigger output 18.
  input  wire logic        trig_gen_out_19, // Trigger output 19.
  input  wire logic        fault_in_2,    // Fault input 2.
  input  wire logic        fault_in_4,    // Fault input 4.
  input  wire logic        cmp_in,        // Comparator output.
  output logic             cmp_gated,     // Blanked comparator output, registered.
  output logic             mask_active    // Mask level, registered.
);
  logic [15:0] src_q, src_d, con_q, con_d;
  logic        gated_q, gated_d, mact_q, mact_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [15:0] sources;
  logic        mask_input_a, mask_input_b, mask_input_c, and_gate_result, or_res;
  logic        wr_src, wr_con, hit;
  logic [3:0]  code_a, code_b, code_c;

  assign sources = {fault_in_4, fault_in_2, trig_gen_out_19, trig_gen_out_18, pwm_outs};
  assign code_c  = src_q[cbm_pkg::SRC_C_LSB +: cbm_pkg::SEL_W];
  assign code_b  = src_q[cbm_pkg::SRC_B_LSB +: cbm_pkg::SEL_W];
  assign code_a  = src_q[cbm_pkg::SRC_A_LSB +: cbm_pkg::SEL_W];

  function automatic logic pick(input logic [15:0] s, input logic [3:0] code);
    pick = s[code];
  endfunction

  // Reads are captured in the setup cycle; a write commits only at the access edge.
  assign hit    = (paddr == cbm_pkg::ADDR_SRC) || (paddr == cbm_pkg::ADDR_CON);
  assign wr_src = psel && penable && pready && pwrite && (paddr == cbm_pkg::ADDR_SRC);
  assign wr_con = psel && penable && pready && pwrite && (paddr == cbm_pkg::ADDR_CON);
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q;

  always_comb begin
    src_d   = src_q;
    con_d   = con_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    if (wr_src) begin
      src_d = pwdata[15:0] & cbm_pkg::SRC_WMASK;
    end
    if (wr_con) begin
      con_d = pwdata[15:0] & cbm_pkg::CON_WMASK;
    end
    if (psel && !penable) begin
      err_d   = !hit;
      rdata_d = 32'h0000_0000;
      if (!pwrite && paddr == cbm_pkg::ADDR_SRC) begin
        rdata_d = {16'h0000, src_q};
      end else if (!pwrite && paddr == cbm_pkg::ADDR_CON) begin
        rdata_d = {16'h0000, con_q};
      end
    end
  end

  always_comb begin
    mask_input_c = pick(sources, code_c);
    mask_input_b = pick(sources, code_b);
    mask_input_a = pick(sources, code_a);
    and_gate_result = ((con_q & cbm_pkg::AND_FIELD) != 16'h0000)
      && (!con_q[cbm_pkg::AND_C_T] || mask_input_c)
      && (!con_q[cbm_pkg::AND_C_N] || !mask_input_c)
      && (!con_q[cbm_pkg::AND_B_T] || mask_input_b)
      && (!con_q[cbm_pkg::AND_B_N] || !mask_input_b)
      && (!con_q[cbm_pkg::AND_A_T] || mask_input_a)
      && (!con_q[cbm_pkg::AND_A_N] || !mask_input_a);
    or_res = (con_q[cbm_pkg::OR_C_T] && mask_input_c)
      || (con_q[cbm_pkg::OR_C_N] && !mask_input_c)
      || (con_q[cbm_pkg::OR_B_T] && mask_input_b)
      || (con_q[cbm_pkg::OR_B_N] && !mask_input_b)
      || (con_q[cbm_pkg::OR_A_T] && mask_input_a)
      || (con_q[cbm_pkg::OR_A_N] && !mask_input_a)
      || (con_q[cbm_pkg::AND_INV_OR] && !and_gate_result)
      || (con_q[cbm_pkg::AND_TRUE_OR] && and_gate_result);
    mact_d = or_res;
    if (!or_res) begin
      gated_d = cmp_in;
    end else if (con_q[cbm_pkg::POL_BIT]) begin
      gated_d = 1'b1;
    end else begin
      gated_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_q   <= cbm_pkg::RST_VAL;
      con_q   <= cbm_pkg::RST_VAL;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      src_q   <= src_d;
      con_q   <= con_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Outputs are registered so the blanked level never glitches while selects settle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gated_q <= 1'b0;
      mact_q  <= 1'b0;
    end else begin
      gated_q <= gated_d;
      mact_q  <= mact_d;
    end
  end

  assign cmp_gated   = gated_q;
  assign mask_active = mact_q;

  // Steps of the register bus and of the mask, used by the properties below.
  sequence seq_wr_src;
    psel && penable && pready && pwrite && (paddr == cbm_pkg::ADDR_SRC);
  endsequence
  sequence seq_wr_con;
    psel && penable && pready && pwrite && (paddr == cbm_pkg::ADDR_CON);
  endsequence
  sequence seq_rd_src;
    psel && !penable && !pwrite && (paddr == cbm_pkg::ADDR_SRC);
  endsequence
  sequence seq_rd_con;
    psel && !penable && !pwrite && (paddr == cbm_pkg::ADDR_CON);
  endsequence
  sequence seq_bad_addr;
    psel && !penable && !hit;
  endsequence
  sequence seq_mask_on;
    or_res;
  endsequence

  AST_SRC_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
    (src_q & ~cbm_pkg::SRC_WMASK) == 16'h0000)
    else $error("source reserved bits set");
  AST_CON_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
    (con_q & ~cbm_pkg::CON_WMASK) == 16'h0000)
    else $error("control reserved bit set");
  AST_WR_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_wr_src |=> src_q == ($past(pwdata[15:0]) & cbm_pkg::SRC_WMASK))
    else $error("source write lost");
  AST_WR_CON: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_wr_con |=> con_q == ($past(pwdata[15:0]) & cbm_pkg::CON_WMASK))
    else $error("control write lost");
  AST_RD_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_rd_src |=> prdata == {16'h0000, $past(src_q)})
    else $error("source read wrong");
  AST_RD_CON: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_rd_con |=> prdata == {16'h0000, $past(con_q)})
    else $error("control read wrong");
  AST_BAD_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_bad_addr |=> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  AST_ERR_OK: assert property (@(posedge mclk) disable iff (!rst_n)
    psel && !penable && hit |=> !pslverr)
    else $error("mapped access refused");

  AST_SEL_C_PWM: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_c < cbm_pkg::SEL_TRIG18) |-> (mask_input_c == pwm_outs[code_c]))
    else $error("C generator pick wrong");
  AST_SEL_C_TRG: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_c == cbm_pkg::SEL_TRIG18) |-> (mask_input_c == trig_gen_out_18))
    else $error("C trigger pick wrong");
  AST_SEL_C_F2: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_c == cbm_pkg::SEL_FAULT_IN_2) |-> (mask_input_c == fault_in_2))
    else $error("C fault 2 pick wrong");
  AST_SEL_C_FLT: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_c == cbm_pkg::SEL_FAULT_IN_4) |-> (mask_input_c == fault_in_4))
    else $error("C fault 4 pick wrong");
  AST_SEL_B_PWM: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_b < cbm_pkg::SEL_TRIG18) |-> (mask_input_b == pwm_outs[code_b]))
    else $error("B generator pick wrong");
  AST_SEL_B_TRG: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_b == cbm_pkg::SEL_TRIG19) |-> (mask_input_b == trig_gen_out_19))
    else $error("B trigger pick wrong");
  AST_SEL_B_FLT: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_b == cbm_pkg::SEL_FAULT_IN_4) |-> (mask_input_b == fault_in_4))
    else $error("B fault pick wrong");
  AST_SEL_A_PWM: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_a < cbm_pkg::SEL_TRIG18) |-> (mask_input_a == pwm_outs[code_a]))
    else $error("A generator pick wrong");
  AST_SEL_A_TRG: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_a == cbm_pkg::SEL_TRIG19) |-> (mask_input_a == trig_gen_out_19))
    else $error("A trigger pick wrong");
  AST_SEL_A_FLT: assert property (@(posedge mclk) disable iff (!rst_n)
    (code_a == cbm_pkg::SEL_FAULT_IN_2) |-> (mask_input_a == fault_in_2))
    else $error("A fault pick wrong");

  AST_PASS: assert property (@(posedge mclk) disable iff (!rst_n)
    !or_res |=> cmp_gated == $past(cmp_in))
    else $error("unmasked not passed");
  AST_BLOCK_HI: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_mask_on ##0 !con_q[cbm_pkg::POL_BIT] |=> !cmp_gated)
    else $error("high not blocked");
  AST_BLOCK_LO: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_mask_on ##0 con_q[cbm_pkg::POL_BIT] |=> cmp_gated)
    else $error("low not blocked");
  AST_NO_TERMS: assert property (@(posedge mclk) disable iff (!rst_n)
    (con_q & cbm_pkg::OR_FIELD) == 16'h0000 |=> !mask_active)
    else $error("mask without terms");
  AST_AND_EMPTY: assert property (@(posedge mclk) disable iff (!rst_n)
    (con_q & cbm_pkg::AND_FIELD) == 16'h0000 |-> !and_gate_result)
    else $error("empty AND nonzero");

  AST_OR_C: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_C_T] && mask_input_c |=> mask_active)
    else $error("C term lost");
  AST_OR_CN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_C_N] && !mask_input_c |=> mask_active)
    else $error("inv C lost");
  AST_OR_B: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_B_T] && mask_input_b |=> mask_active)
    else $error("B term lost");
  AST_OR_BN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_B_N] && !mask_input_b |=> mask_active)
    else $error("inv B lost");
  AST_OR_A: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_A_T] && mask_input_a |=> mask_active)
    else $error("A term lost");
  AST_OR_AN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::OR_A_N] && !mask_input_a |=> mask_active)
    else $error("inv A lost");
  AST_OR_NAND: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_INV_OR] && !and_gate_result |=> mask_active)
    else $error("inv AND lost");
  AST_OR_AND: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_TRUE_OR] && and_gate_result |=> mask_active)
    else $error("AND term lost");

  AST_AND_C: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_C_T] && !mask_input_c |-> !and_gate_result)
    else $error("AND C ignored");
  AST_AND_CN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_C_N] && mask_input_c |-> !and_gate_result)
    else $error("AND inv C ignored");
  AST_AND_B: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_B_T] && !mask_input_b |-> !and_gate_result)
    else $error("AND B ignored");
  AST_AND_BN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_B_N] && mask_input_b |-> !and_gate_result)
    else $error("AND inv B ignored");
  AST_AND_A: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_A_T] && !mask_input_a |-> !and_gate_result)
    else $error("AND A ignored");
  AST_AND_AN: assert property (@(posedge mclk) disable iff (!rst_n)
    con_q[cbm_pkg::AND_A_N] && mask_input_a |-> !and_gate_result)
    else $error("AND inv A ignored");
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, pwm_outs;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, cmp_gated, mask_active, t18, t19, f2, f4, cmp_in, a, b, c, an, orr;
  logic [15:0] src_m = 16'h0000, con_m = 16'h0000, s;
  logic [1:0]  exp_q[$];
  integer      n_mismatch = 0, checked = 0, seed = 32'hbfff4195, i;
  always #2.5 mclk = ~mclk;
  cbm_top cbm_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_outs(pwm_outs), .trig_gen_out_18(t18), .trig_gen_out_19(t19),
    .fault_in_2(f2), .fault_in_4(f4), .cmp_in(cmp_in), .cmp_gated(cmp_gated),
    .mask_active(mask_active));
  cbm_src_model cbm_src_model_inst (.mclk(mclk), .pwm_outs(pwm_outs), .trig_18(t18),
    .trig_19(t19), .fault_2(f2), .fault_4(f4), .cmp_in(cmp_in));
  task check(input logic [31:0] seen, input logic [31:0] expd);
    checked++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bit 32 of ex is the expected error flag, the rest the expected read data.
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, input logic [32:0] ex);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // The loop waits for pready; cbm_top ties it high, so the access phase ends at its first edge.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    check({31'h0, pslverr}, {31'h0, ex[32]});
    if (!wr) check(prdata, ex[31:0]);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Registered outputs are looked at 1 ns after the edge that launches them.
  always @(posedge mclk) begin
    #1;
    if (rst_n && exp_q.size() > 0) begin
      check({30'h0, mask_active, cmp_gated}, {30'h0, exp_q.pop_front()});
    end
  end
  // Notes are taken mid-cycle, where inputs and registers have settled.
  always @(negedge mclk) begin
    if (!rst_n) begin
      exp_q.delete();
      src_m = 16'h0000;
      con_m = 16'h0000;
    end else begin
      s = {f4, f2, t19, t18, pwm_outs};
      c = s[src_m[11:8]];
      b = s[src_m[7:4]];
      a = s[src_m[3:0]];
      an = (con_m[5:0] != 6'h00) & (c | ~con_m[5]) & (~c | ~con_m[4]) & (b | ~con_m[3])
         & (~b | ~con_m[2]) & (a | ~con_m[1]) & (~a | ~con_m[0]);
      orr = |(con_m[13:6] & {c, ~c, b, ~b, a, ~a, ~an, an});
      exp_q.push_back({orr, orr ? con_m[15] : cmp_in});
      // A write lands at the access edge that closes this cycle.
      if (psel && penable && pready && pwrite && paddr == cbm_pkg::ADDR_SRC) begin
        src_m = pwdata[15:0] & 16'h0fff;
      end
      if (psel && penable && pready && pwrite && paddr == cbm_pkg::ADDR_CON) begin
        con_m = pwdata[15:0] & 16'hbfff;
      end
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, 12'h000, 32'h0, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h0);
    apb(1'b1, 12'h000, 32'hffffffff, 33'h0);
    apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0fff);
    apb(1'b1, 12'h004, 32'hffffffff, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h0_0000_bfff);
    apb(1'b1, 12'h008, 32'h1, 33'h1_0000_0000);
    apb(1'b0, 12'h008, 32'h0, 33'h1_0000_0000);
    // The first sixteen passes walk every source code through all three selectors.
    for (i = 0; i < 400; i++) begin
      apb(1'b1, 12'h000, (i < 16) ? {20'h0, {3{i[3:0]}}} : $random(seed), 33'h0);
      apb(1'b1, 12'h004, $random(seed), 33'h0);
      repeat (3) @(posedge mclk);
    end
    // A second reset in mid-run must clear both registers again.
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, 12'h000, 32'h0, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h0);
    repeat (3) @(posedge mclk);
    end_of_test;
  end
endmodule
